// ---- half_bridge_fault_control.sv ----
`timescale 1ns/1ps
// Behaviour
// - Enable low puts the device to sleep with every driver off.
// - Drivers start off and stay off during any supply undervoltage.
// - Frames are taken while enable is high; load undervoltage still blocks outputs.
// - Each of the three half-bridges is switched independently.
// - Overcurrent with shutdown disabled sets overload flag; driver stays on.
// - Overcurrent with shutdown enabled for 25 us sets flag, latches driver off.
// - Current limit beyond 200 us latches the driver off regardless.
// - After current-limit shutdown the switch status reads 0; overload stays set.
// - Enabled driver under-loaded past the delay sets under-load flag, bit 14.
// - Load overvoltage sets supply-fail flag, bit 15, cleared only by status reset.
// - With lockout enabled, overvoltage turns outputs off and later restores them.
// - Three thermal sensors, one per half-bridge, each with warning and shutdown.
// - Thermal warning sets bit 0, outputs stay on, flag stays latched.
// - Status reset clears thermal warning only once below warning level.
// - Thermal shutdown latches all drivers off until cooled and status reset.
// - No driver turns on while any sensor is above shutdown level.
// - Chip select falling drives thermal warning onto serial output immediately.
// - Warning level holds on serial output while the serial clock is idle.
// - 16-bit frames, LSB first, taken on chip select rise; output floats when high.
// - Only frames of at least 16 bits are latched; faults re-latch after filtering.
// - Status word: 15 supply fail, 14 under-load, 13 overload, 6..1 switches, 0 warning.
module half_bridge_fault_control #(
  parameter int unsigned OC_FILTER = hb_ctrl_pkg::OC_FILTER_CYC,
  parameter int unsigned CL_FILTER = hb_ctrl_pkg::CL_FILTER_CYC,
  parameter int unsigned UL_DELAY = hb_ctrl_pkg::UL_DELAY_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic enable,
  input wire logic loadSupplyUv,
  input wire logic loadSupplyOv,
  input wire logic [5:0] overcurrentDet,
  input wire logic [5:0] currentLimitDet,
  input wire logic [5:0] underloadDet,
  input wire logic [2:0] thermalWarnDet,
  input wire logic [2:0] thermalShutDet,
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic serialIn,
  output logic serialOut,
  output logic serialOutEnable,
  output logic highSideSwitch1,
  output logic lowSideSwitch1,
  output logic highSideSwitch2,
  output logic lowSideSwitch2,
  output logic highSideSwitch3,
  output logic lowSideSwitch3,
  output logic sleepMode,
  output logic overloadFlag,
  output logic underloadFlag,
  output logic supplyFailFlag,
  output logic thermalWarningFlag,
  output logic overcurrentShutdownEnable,
  output logic overvoltageLockoutEnable,
  output logic frameAccepted
);

  localparam int unsigned NSW = hb_ctrl_pkg::NUM_SWITCHES;
  localparam int unsigned NBR = hb_ctrl_pkg::NUM_BRIDGES;
  localparam int unsigned NASYNC = 1 + 1 + 1 + NSW * 3 + NBR * 2 + 1;

  // Map a switch to the bridge whose thermal sensor it shares
  function automatic logic [NSW-1:0] bridgeToSwitches(input logic [NBR-1:0] perBridge);
    logic [NSW-1:0] res;
    res = '0;
    for (int i = 0; i < NSW; i++) begin
      res[i] = perBridge[i / 2];
    end
    return res;
  endfunction

  // Reset release through two flops; assertion stays asynchronous
  logic rstMeta;
  logic rstN;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstN <= rstMeta;
    end
  end

  // Every pin-level input except serial clock and data, chip select among them, passes two flops
  logic [NASYNC-1:0] asyncIn;
  logic [NASYNC-1:0] syncMeta;
  logic [NASYNC-1:0] syncReg;

  assign asyncIn = {enable, loadSupplyUv, loadSupplyOv, overcurrentDet, currentLimitDet,
                    underloadDet, thermalWarnDet, thermalShutDet, chip_select_n};

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      // Chip select idles high, so no false rise follows reset
      syncMeta <= {{(NASYNC-1){1'b0}}, 1'b1};
      syncReg <= {{(NASYNC-1){1'b0}}, 1'b1};
    end else begin
      syncMeta <= asyncIn;
      syncReg <= syncMeta;
    end
  end

  logic enS;
  logic uvS;
  logic ovS;
  logic [NSW-1:0] ocS;
  logic [NSW-1:0] clS;
  logic [NSW-1:0] ulS;
  logic [NBR-1:0] twS;
  logic [NBR-1:0] tsS;
  logic csS;

  assign {enS, uvS, ovS, ocS, clS, ulS, twS, tsS, csS} = syncReg;

  // Serial link on its own clock; core reads its word after chip select rises
  logic [15:0] statusHold;
  logic [15:0] rxWord;
  logic rxLong;

  hb_spi_link link (
    .sclk(sclk),
    .rstN(rstN),
    .chipSelectN(chip_select_n),
    .serialIn(serialIn),
    .statusWord(statusHold),
    .serialOut(serialOut),
    .serialOutEnable(serialOutEnable),
    .rxWord(rxWord),
    .rxLong(rxLong)
  );

  // Chip select edge seen in the core domain
  logic csPrev;

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      csPrev <= 1'b1;
    end else begin
      csPrev <= csS;
    end
  end

  logic csRise;
  logic frameTake;
  logic srrTake;

  assign csRise = csS && !csPrev;
  // accepted whenever enable is high, load supply aside
  assign frameTake = csRise && rxLong && enS;
  assign srrTake = frameTake && rxWord[hb_ctrl_pkg::IN_SRR_BIT];

  // Control register; unused command bits never stored
  logic ocdEnReg;
  logic ovloEnReg;
  logic [NSW-1:0] switchCmdReg;

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      ocdEnReg <= 1'b0;
      ovloEnReg <= 1'b0;
      switchCmdReg <= hb_ctrl_pkg::SWITCH_RESET;
    end else if (frameTake) begin
      ocdEnReg <= rxWord[hb_ctrl_pkg::IN_OCD_BIT];
      ovloEnReg <= rxWord[hb_ctrl_pkg::IN_OVERVOLTAGE_LOCKOUT_ENABLE_BIT];
      switchCmdReg <= rxWord[hb_ctrl_pkg::IN_SW_LSB +: NSW];
    end
  end

  // Filter timers per switch; a status reset restarts them so faults re-latch later
  logic [NSW-1:0] ocExpired;
  logic [NSW-1:0] clExpired;
  logic [NSW-1:0] ulExpired;
  logic [NSW-1:0] driveReg;

  genvar g;
  generate
    for (g = 0; g < NSW; g++) begin : gen_timers
      hb_fault_timer #(.COUNT(OC_FILTER)) ocTimer (
        .clk(ref_clk),
        .rstN(rstN),
        .active(ocS[g]),
        .restart(srrTake),
        .expired(ocExpired[g])
      );
      hb_fault_timer #(.COUNT(CL_FILTER)) clTimer (
        .clk(ref_clk),
        .rstN(rstN),
        .active(clS[g]),
        .restart(srrTake),
        .expired(clExpired[g])
      );
      hb_fault_timer #(.COUNT(UL_DELAY)) ulTimer (
        .clk(ref_clk),
        .rstN(rstN),
        .active(ulS[g] && driveReg[g]),
        .restart(srrTake),
        .expired(ulExpired[g])
      );
    end
  endgenerate

  // Per-switch latch-off; set wins over a status reset in the same cycle
  logic [NSW-1:0] offLatchReg;
  logic [NSW-1:0] offLatchSet;

  assign offLatchSet = (ocExpired & {NSW{ocdEnReg}}) | clExpired;

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      offLatchReg <= '0;
    end else begin
      offLatchReg <= offLatchSet | (offLatchReg & {NSW{!srrTake}});
    end
  end

  // shutdown latch, cleared only by a status reset after cooling
  logic [NBR-1:0] thermOffReg;

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      thermOffReg <= '0;
    end else begin
      thermOffReg <= tsS | (thermOffReg & {NBR{!srrTake}});
    end
  end

  // Gating of programmed states into the drivers
  logic [NSW-1:0] driveNext;
  logic anyThermOff;

  // one sensor per bridge, but any shutdown takes all drivers off
  assign anyThermOff = |(thermOffReg | tsS);

  always_comb begin
    driveNext = switchCmdReg & ~offLatchReg & ~offLatchSet;
    if (anyThermOff || |bridgeToSwitches(tsS)) begin
      driveNext = '0;
    end
    // lockout hides the outputs but keeps the programmed state
    if (ovloEnReg && ovS) begin
      driveNext = '0;
    end
    // load supply undervoltage holds everything off
    if (uvS) begin
      driveNext = '0;
    end
    if (!enS) begin
      driveNext = '0;
    end
  end

  // each switch driven from its own bit
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      driveReg <= hb_ctrl_pkg::SWITCH_RESET;
    end else begin
      driveReg <= driveNext;
    end
  end

  // Latched fault flags; the event wins over a clear arriving with it
  logic olSet;
  logic ulSet;
  logic twSet;

  // raw overcurrent sets overload when shutdown is off
  assign olSet = (|ocS && !ocdEnReg) | (|ocExpired) | (|clExpired);
  // under-load only counts while the driver is on
  assign ulSet = |ulExpired;
  assign twSet = |twS;

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      overloadFlag <= 1'b0;
    end else begin
      overloadFlag <= olSet | (overloadFlag & !srrTake);
    end
  end

  // outputs unaffected, flag held until status reset
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      underloadFlag <= 1'b0;
    end else begin
      underloadFlag <= ulSet | (underloadFlag & !srrTake);
    end
  end

  // supply fail follows overvoltage and latches
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      supplyFailFlag <= 1'b0;
    end else begin
      supplyFailFlag <= ovS | (supplyFailFlag & !srrTake);
    end
  end

  // warning latched after cooling, outputs left on
  // a live warning keeps the flag through a status reset
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      thermalWarningFlag <= 1'b0;
    end else begin
      thermalWarningFlag <= twSet | (thermalWarningFlag & !srrTake);
    end
  end

  // Status word, frozen while chip select is low so the shifter sees it steady
  logic [15:0] statusNext;

  // switch bits show actual drive, so a shut-down switch reads 0
  always_comb begin
    statusNext = hb_ctrl_pkg::STATUS_RESET;
    statusNext[hb_ctrl_pkg::OUT_PSF_BIT] = supplyFailFlag;
    statusNext[hb_ctrl_pkg::OUT_ULD_BIT] = underloadFlag;
    statusNext[hb_ctrl_pkg::OUT_OLD_BIT] = overloadFlag;
    statusNext[hb_ctrl_pkg::OUT_SW_LSB +: NSW] = driveReg;
    statusNext[hb_ctrl_pkg::OUT_TW_BIT] = thermalWarningFlag;
  end

  // warning bit ready before chip select falls
  // held steady for the whole frame
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      statusHold <= hb_ctrl_pkg::STATUS_RESET;
    end else if (csS && csPrev && chip_select_n) begin
      statusHold <= statusNext;
    end
  end

  // frame handed over on chip select rise
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      frameAccepted <= 1'b0;
    end else begin
      frameAccepted <= frameTake;
    end
  end

  // sleep indication follows the enable pin
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      sleepMode <= 1'b1;
    end else begin
      sleepMode <= !enS;
    end
  end

  // Mode bits mirrored out for observation
  assign overcurrentShutdownEnable = ocdEnReg;
  assign overvoltageLockoutEnable = ovloEnReg;

  // Switch pins: bit 0 low side 1, bit 5 high side 3
  assign lowSideSwitch1 = driveReg[0];
  assign highSideSwitch1 = driveReg[1];
  assign lowSideSwitch2 = driveReg[2];
  assign highSideSwitch2 = driveReg[3];
  assign lowSideSwitch3 = driveReg[4];
  assign highSideSwitch3 = driveReg[5];

endmodule

// ---- hb_ctrl_pkg.sv ----
package hb_ctrl_pkg;

  // Frame geometry
  localparam int unsigned WORD_BITS = 16;
  localparam int unsigned COUNT_BITS = 5;
  localparam int unsigned NUM_BRIDGES = 3;
  localparam int unsigned NUM_SWITCHES = 6;

  // Command word field positions
  localparam int unsigned IN_OVERVOLTAGE_LOCKOUT_ENABLE_BIT = 15;
  localparam int unsigned IN_OCD_BIT = 13;
  localparam int unsigned IN_SW_LSB = 1;
  localparam int unsigned IN_SRR_BIT = 0;

  // Status word field positions
  localparam int unsigned OUT_PSF_BIT = 15;
  localparam int unsigned OUT_ULD_BIT = 14;
  localparam int unsigned OUT_OLD_BIT = 13;
  localparam int unsigned OUT_SW_LSB = 1;
  localparam int unsigned OUT_TW_BIT = 0;

  // Reset values
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [5:0] SWITCH_RESET = 6'h00;

  // Timing, figures in microseconds and the core clock rate
  localparam int unsigned CLK_MHZ = 10;
  localparam int unsigned OC_FILTER_US = 25;
  localparam int unsigned CL_FILTER_US = 200;
  localparam int unsigned UL_DELAY_US = 200;
  localparam int unsigned OC_FILTER_CYC = OC_FILTER_US * CLK_MHZ;
  localparam int unsigned CL_FILTER_CYC = CL_FILTER_US * CLK_MHZ;
  localparam int unsigned UL_DELAY_CYC = UL_DELAY_US * CLK_MHZ;

endpackage

// ---- hb_fault_timer.sv ----
`timescale 1ns/1ps
module hb_fault_timer #(
  parameter int unsigned COUNT = 250
) (
  input wire logic clk,
  input wire logic rstN,
  input wire logic active,
  input wire logic restart,
  output logic expired
);

  localparam int unsigned CW = $clog2(COUNT + 1);
  localparam logic [CW-1:0] LIMIT = CW'(COUNT);

  logic [CW-1:0] cntReg;

  // Run while the condition persists; restart drops any partial count
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      cntReg <= '0;
    end else if (!active || restart) begin
      cntReg <= '0;
    end else if (cntReg != LIMIT) begin
      cntReg <= cntReg + CW'(1);
    end
  end

  // Level, high while the condition has lasted the full filter time
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      expired <= 1'b0;
    end else begin
      expired <= active && !restart && (cntReg == LIMIT);
    end
  end

endmodule

// ---- hb_spi_link.sv ----
`timescale 1ns/1ps
module hb_spi_link (
  input wire logic sclk,
  input wire logic rstN,
  input wire logic chipSelectN,
  input wire logic serialIn,
  input wire logic [15:0] statusWord,
  output logic serialOut,
  output logic serialOutEnable,
  output logic [15:0] rxWord,
  output logic rxLong
);

  logic firstEdge;
  logic [15:0] shiftReg;
  logic [4:0] bitCount;
  logic frameToggle;
  logic countToggle;

  // Flips at every select fall; a frame with no clock edge leaves the count stale
  always_ff @(negedge chipSelectN or negedge rstN) begin
    if (!rstN) begin
      frameToggle <= 1'b0;
    end else begin
      frameToggle <= ~frameToggle;
    end
  end

  // Copied at the first clock of a frame, so old counts are never taken again
  always_ff @(posedge sclk or negedge rstN) begin
    if (!rstN) begin
      countToggle <= 1'b0;
    end else if (firstEdge) begin
      countToggle <= frameToggle;
    end
  end

  // Armed by chip select high, so bit 0 shows before any clock
  always_ff @(posedge sclk or posedge chipSelectN) begin
    if (chipSelectN) begin
      firstEdge <= 1'b1;
    end else begin
      firstEdge <= 1'b0;
    end
  end

  // One shifter: status leaves at bit 0, command enters at bit 15
  always_ff @(posedge sclk or negedge rstN) begin
    if (!rstN) begin
      shiftReg <= 16'h0000;
    end else if (firstEdge) begin
      shiftReg <= {serialIn, statusWord[15:1]};
    end else begin
      shiftReg <= {serialIn, shiftReg[15:1]};
    end
  end

  // Saturating length; left standing after the frame for the core to read
  always_ff @(posedge sclk or negedge rstN) begin
    if (!rstN) begin
      bitCount <= 5'h00;
    end else if (firstEdge) begin
      bitCount <= 5'h01;
    end else if (bitCount != hb_ctrl_pkg::COUNT_BITS'(hb_ctrl_pkg::WORD_BITS)) begin
      bitCount <= bitCount + 5'h01;
    end
  end

  // The pin must answer chip select with no clock edge, hence no flop here
  assign serialOut = firstEdge ? statusWord[hb_ctrl_pkg::OUT_TW_BIT] : shiftReg[0];
  assign serialOutEnable = ~chipSelectN;
  assign rxWord = shiftReg;
  assign rxLong = (bitCount == hb_ctrl_pkg::COUNT_BITS'(hb_ctrl_pkg::WORD_BITS)) &&
                  (countToggle == frameToggle);

endmodule

// ---- hb_ctrl_props.sv ----
`timescale 1ns/1ps
module hb_ctrl_props #(
  parameter int unsigned OC_FILTER = 4,
  parameter int unsigned CL_FILTER = 8
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic loadSupplyUv,
  input wire logic loadSupplyOv,
  input wire logic [5:0] overcurrentDet,
  input wire logic [5:0] currentLimitDet,
  input wire logic [2:0] thermalWarnDet,
  input wire logic [2:0] thermalShutDet,
  input wire logic chip_select_n,
  input wire logic serialOutEnable,
  input wire logic highSideSwitch1,
  input wire logic lowSideSwitch1,
  input wire logic highSideSwitch2,
  input wire logic lowSideSwitch2,
  input wire logic highSideSwitch3,
  input wire logic lowSideSwitch3,
  input wire logic sleepMode,
  input wire logic overloadFlag,
  input wire logic supplyFailFlag,
  input wire logic thermalWarningFlag,
  input wire logic overcurrentShutdownEnable,
  input wire logic overvoltageLockoutEnable,
  input wire logic frameAccepted
);
  logic anyOn;
  logic [15:0] ocCnt;
  logic [15:0] clCnt;
  // Any driver pin on
  assign anyOn = highSideSwitch1 | lowSideSwitch1 | highSideSwitch2 | lowSideSwitch2
    | highSideSwitch3 | lowSideSwitch3;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  // Overcurrent run length; a frame restarts it, as status reset re-arms the filter
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ocCnt <= 16'h0000;
    end else if (frameAccepted || !(overcurrentDet[1] && overcurrentShutdownEnable)) begin
      ocCnt <= 16'h0000;
    end else if (ocCnt != 16'hFFFF) begin
      ocCnt <= ocCnt + 16'h0001;
    end
  end
  // Current limit run length, same restart reasoning
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      clCnt <= 16'h0000;
    end else if (frameAccepted || !currentLimitDet[0]) begin
      clCnt <= 16'h0000;
    end else if (clCnt != 16'hFFFF) begin
      clCnt <= clCnt + 16'h0001;
    end
  end
  chk_sleep_off: assert property (sleepMode [*3] |-> !anyOn) else $error("driver on asleep");
  chk_uv_off: assert property (loadSupplyUv [*5] |-> !anyOn) else $error("driver on in uv");
  chk_hot_off: assert property ((thermalShutDet != 3'h0) [*5] |-> !anyOn)
    else $error("driver on while hot");
  chk_lock_off: assert property ((loadSupplyOv && overvoltageLockoutEnable) [*5] |-> !anyOn)
    else $error("driver on in lockout");
  chk_fail_set: assert property (loadSupplyOv [*4] |-> supplyFailFlag)
    else $error("supply fail not set");
  chk_fail_keep: assert property ($fell(supplyFailFlag) |-> frameAccepted)
    else $error("supply fail cleared without frame");
  chk_warn_set: assert property ((thermalWarnDet != 3'h0) [*4] |-> thermalWarningFlag)
    else $error("warning flag low while warm");
  chk_load_flag: assert property ((overcurrentDet[1] && !overcurrentShutdownEnable) [*4]
    |-> overloadFlag) else $error("overload flag not set");
  chk_oc_latch: assert property (ocCnt > OC_FILTER + 6 |-> !highSideSwitch1 && overloadFlag)
    else $error("overcurrent did not latch off");
  chk_cl_latch: assert property (clCnt > CL_FILTER + 6 |-> !lowSideSwitch1 && overloadFlag)
    else $error("current limit did not latch off");
  chk_so_float: assert property (chip_select_n |-> !serialOutEnable)
    else $error("serial output driven while deselected");
  chk_take_gap: assert property (frameAccepted |-> $past(chip_select_n, 3) ##1 !frameAccepted)
    else $error("frame taken while selected");
endmodule
bind half_bridge_fault_control hb_ctrl_props #(.OC_FILTER(OC_FILTER), .CL_FILTER(CL_FILTER))
  i_hb_ctrl_props (.ref_clk(ref_clk), .rst_b(rst_b), .loadSupplyUv(loadSupplyUv),
  .loadSupplyOv(loadSupplyOv), .overcurrentDet(overcurrentDet), .currentLimitDet(currentLimitDet),
  .thermalWarnDet(thermalWarnDet), .thermalShutDet(thermalShutDet),
  .chip_select_n(chip_select_n), .serialOutEnable(serialOutEnable),
  .highSideSwitch1(highSideSwitch1), .lowSideSwitch1(lowSideSwitch1),
  .highSideSwitch2(highSideSwitch2), .lowSideSwitch2(lowSideSwitch2),
  .highSideSwitch3(highSideSwitch3), .lowSideSwitch3(lowSideSwitch3), .sleepMode(sleepMode),
  .overloadFlag(overloadFlag), .supplyFailFlag(supplyFailFlag),
  .thermalWarningFlag(thermalWarningFlag), .frameAccepted(frameAccepted),
  .overcurrentShutdownEnable(overcurrentShutdownEnable),
  .overvoltageLockoutEnable(overvoltageLockoutEnable));

// ---- hb_spi_host.sv ----
`timescale 1ns/1ps
module hb_spi_host (
  output logic sclk,
  output logic chipSelectN,
  output logic serialIn,
  input wire logic serialOut
);
  // Idle levels follow the pull-downs on clock and data, pull-up on select
  initial begin
    sclk = 1'b0;
    chipSelectN = 1'b1;
    serialIn = 1'b0;
  end
  task automatic select();
    #7 chipSelectN = 1'b0;
  endtask
  task automatic deselect();
    #10 chipSelectN = 1'b1;
    #600;
  endtask
  // LSB first, clock only inside frame, low at select rise
  task automatic xfer(input logic [15:0] cmd, input int nBits, output logic [15:0] st);
    st = 16'h0000;
    select();
    #10;
    for (int k = 0; k < nBits; k++) begin
      if (k < 16) st[k] = serialOut;
      serialIn = cmd[k % 16];
      #3 sclk = 1'b1;
      #3 sclk = 1'b0;
    end
    serialIn = 1'b0;
    deselect();
  endtask
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  logic ref_clk, rst_b, enable, loadSupplyUv, loadSupplyOv;
  logic [5:0] overcurrentDet, currentLimitDet, underloadDet;
  logic [2:0] thermalWarnDet, thermalShutDet;
  wire logic sclk, chipSelectN, serialIn, serialOut, serialOutEnable, frameAccepted;
  wire logic [5:0] swState;
  wire logic sleepMode, overloadFlag, underloadFlag, supplyFailFlag, thermalWarningFlag;
  wire logic shutEn, lockEn;
  logic [15:0] stat;
  logic [5:0] swExp, swPrev;
  int err_total = 0, n_compared = 0, nAcc = 0, accSeen = 0, cycles = 0;
  // Short filters keep the run brief
  half_bridge_fault_control #(.OC_FILTER(4), .CL_FILTER(8), .UL_DELAY(8))
    i_half_bridge_fault_control (.ref_clk(ref_clk), .rst_b(rst_b), .enable(enable),
    .loadSupplyUv(loadSupplyUv), .loadSupplyOv(loadSupplyOv), .overcurrentDet(overcurrentDet),
    .currentLimitDet(currentLimitDet), .underloadDet(underloadDet),
    .thermalWarnDet(thermalWarnDet), .thermalShutDet(thermalShutDet), .sclk(sclk),
    .chip_select_n(chipSelectN), .serialIn(serialIn), .serialOut(serialOut),
    .serialOutEnable(serialOutEnable), .lowSideSwitch1(swState[0]),
    .highSideSwitch1(swState[1]), .lowSideSwitch2(swState[2]), .highSideSwitch2(swState[3]),
    .lowSideSwitch3(swState[4]), .highSideSwitch3(swState[5]), .sleepMode(sleepMode),
    .overloadFlag(overloadFlag), .underloadFlag(underloadFlag),
    .supplyFailFlag(supplyFailFlag), .thermalWarningFlag(thermalWarningFlag),
    .overcurrentShutdownEnable(shutEn), .overvoltageLockoutEnable(lockEn),
    .frameAccepted(frameAccepted));
  hb_spi_host i_hb_spi_host (.sclk(sclk), .chipSelectN(chipSelectN), .serialIn(serialIn),
    .serialOut(serialOut));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Frames taken, and a ceiling well past the expected run
  always @(posedge ref_clk) begin
    cycles++;
    if (frameAccepted === 1'b1) nAcc++;
    if (cycles == 4000) begin
      err_total++;
      complete_run();
    end
  end
  task automatic waitc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic send(input logic [15:0] c, input int bits = 16);
    accSeen = nAcc;
    i_hb_spi_host.xfer(c, bits, stat);
    waitc(4);
  endtask
  task automatic pins(input logic [5:0] e);
    check({10'h000, swState}, {10'h000, e});
  endtask
  // Stimulus sequence, all inputs but the serial pins move on falling edges only
  initial begin
    {rst_b, enable, loadSupplyUv, loadSupplyOv} = 4'h0;
    {overcurrentDet, currentLimitDet, underloadDet} = 18'h00000;
    {thermalWarnDet, thermalShutDet} = 6'h00;
    waitc(20);
    rst_b = 1'b1;
    waitc(6);
    send(16'h007E);
    check({15'h0000, sleepMode}, 16'h0001);
    check(16'(nAcc - accSeen), 16'h0000);
    pins(6'h00);
    enable = 1'b1;
    waitc(6);
    // each switch alone, then all six together, with unused bits set
    swPrev = 6'h00;
    for (int i = 0; i < 7; i++) begin
      swExp = (i == 6) ? 6'h3F : 6'h01 << i;
      send(16'h5F80 | {9'h000, swExp, 1'b0});
      pins(swExp);
      check(stat, {9'h000, swPrev, 1'b0});
      swPrev = swExp;
    end
    send(16'h0000, 8);
    check(16'(nAcc - accSeen), 16'h0000);
    pins(6'h3F);
    thermalWarnDet = 3'h2;
    waitc(5);
    check({thermalWarningFlag, 9'h000, swState}, 16'h803F);
    send(16'h007F);
    check({15'h0000, thermalWarningFlag}, 16'h0001);
    // Quick look right after a valid frame must not take that frame again
    accSeen = nAcc;
    i_hb_spi_host.select();
    #20 check({14'h0000, serialOutEnable, serialOut}, 16'h0003);
    #300 check({14'h0000, serialOutEnable, serialOut}, 16'h0003);
    i_hb_spi_host.deselect();
    check({15'h0000, serialOutEnable}, 16'h0000);
    waitc(1);
    check(16'(nAcc - accSeen), 16'h0000);
    thermalWarnDet = 3'h0;
    waitc(4);
    send(16'h007F);
    check({15'h0000, thermalWarningFlag}, 16'h0000);
    thermalShutDet = 3'h4;
    waitc(5);
    pins(6'h00);
    send(16'h007F);
    pins(6'h00);
    thermalShutDet = 3'h0;
    waitc(4);
    send(16'h007E);
    pins(6'h00);
    send(16'h007F);
    pins(6'h3F);
    send(16'h807E);
    loadSupplyOv = 1'b1;
    waitc(5);
    check({supplyFailFlag, lockEn, 8'h00, swState}, 16'hC000);
    loadSupplyOv = 1'b0;
    waitc(5);
    check({supplyFailFlag, lockEn, 8'h00, swState}, 16'hC03F);
    send(16'h007F);
    check({supplyFailFlag, lockEn, 8'h00, swState}, 16'h003F);
    loadSupplyOv = 1'b1;
    waitc(5);
    check({supplyFailFlag, lockEn, 8'h00, swState}, 16'h803F);
    loadSupplyOv = 1'b0;
    waitc(3);
    send(16'h007F);
    overcurrentDet = 6'h02;
    waitc(20);
    check({overloadFlag, shutEn, 8'h00, swState}, 16'h803F);
    overcurrentDet = 6'h00;
    waitc(3);
    send(16'h207F);
    overcurrentDet = 6'h02;
    waitc(20);
    check({overloadFlag, shutEn, 8'h00, swState}, 16'hC03D);
    overcurrentDet = 6'h00;
    waitc(3);
    send(16'h207E);
    pins(6'h3D);
    send(16'h007F);
    check({overloadFlag, shutEn, 8'h00, swState}, 16'h003F);
    currentLimitDet = 6'h01;
    waitc(20);
    check({overloadFlag, 9'h000, swState}, 16'h803E);
    currentLimitDet = 6'h00;
    waitc(3);
    send(16'h007E);
    check(stat, 16'h207C);
    pins(6'h3E);
    send(16'h007F);
    pins(6'h3F);
    underloadDet = 6'h08;
    waitc(20);
    check({underloadFlag, 9'h000, swState}, 16'h803F);
    underloadDet = 6'h00;
    waitc(3);
    send(16'h007F);
    check(stat, 16'h407E);
    check({15'h0000, underloadFlag}, 16'h0000);
    loadSupplyUv = 1'b1;
    waitc(5);
    pins(6'h00);
    send(16'h0003);
    check(16'(nAcc - accSeen), 16'h0001);
    pins(6'h00);
    loadSupplyUv = 1'b0;
    waitc(5);
    pins(6'h01);
    enable = 1'b0;
    waitc(5);
    check({sleepMode, 9'h000, swState}, 16'h8000);
    complete_run();
  end
endmodule
